//--- inc/dspac_pkg.sv
// Constants and types shared by the serdes channel design files
package dspac_pkg;
    // Register byte offsets
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_STAT      = 8'h04;
    // Control register width, reset value and rollover point limits
    localparam int          CTRL_W        = 24;
    localparam logic [23:0] CTRL_RESET    = 24'hb00024;
    localparam logic [3:0]  ROLL_MIN      = 4'h1;
    localparam logic [3:0]  ROLL_MAX      = 4'hb;
    // Status register field positions
    localparam int          STAT_LOCK     = 0;
    localparam int          STAT_ROLL     = 1;
    localparam int          STAT_SLIP_LSB = 2;
    localparam int          STAT_PH_LSB   = 6;
    localparam int          STAT_FCNT_LSB = 9;
    localparam int          STAT_AL_LSB   = 12;
    // Receive path counts
    localparam logic [7:0]  LOCK_SETTLE   = 8'h10;
    localparam logic [2:0]  FIFO_LAST     = 3'h5;
    localparam logic [2:0]  FIFO_PRIME    = 3'h3;
    localparam logic [3:0]  WORD_MAX      = 4'ha;

    // Control register layout, bit 0 at the bottom
    typedef struct packed {
        logic [3:0] roll;      // Slip rollover point, 1 to 11
        logic       lk_mode;   // 0: lock drops on any move
        logic [2:0] ck_phase;  // Extra clock phase, 45 degree steps
        logic       ck_ctr;    // Forwarded clock center aligned
        logic [2:0] ck_div;    // 0 rate, 1 /2, 2 /4, 3 /8, 4 /10
        logic       ck_en;     // Forwarded clock enable
        logic       scdr;      // Soft clock-recovery mode
        logic       rx_ddr;    // Receive bypass double rate
        logic       rx_byp;    // Receive deserializer bypass
        logic       tx_ddr;    // Transmit bypass double rate
        logic       tx_byp;    // Transmit serializer bypass
        logic [2:0] rxf;       // Receive factor select
        logic [2:0] txf;       // Transmit factor select
    } dspac_cfg_s;

    // Phase aligner states
    typedef enum logic [1:0] {AL_IDLE, AL_TRACK, AL_LOCKED} dspac_al_e;

    // Factor select to bits per word
    function automatic logic [3:0] fact_of(input logic [2:0] sel);
        case (sel)
            3'h0:    fact_of = 4'h4;
            3'h1:    fact_of = 4'h6;
            3'h2:    fact_of = 4'h7;
            3'h3:    fact_of = 4'h8;
            default: fact_of = 4'ha;
        endcase
    endfunction
endpackage

//--- rtl/dspac_tx.sv
// Transmit serializer with forwarded clock and bypass registers
`timescale 1ns/100ps
`default_nettype none
module dspac_tx
    import dspac_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire dspac_cfg_s cfg,
    input  wire logic [9:0] tx_word,
    output logic            tx_load_strobe,
    output logic            tx_serial_out,
    output logic [1:0]      tx_clk_out,
    output logic [1:0]      tx_ddr_out
);
    typedef struct packed {
        logic [3:0] cnt;
        logic [9:0] sh;
        logic       ser;
        logic [4:0] cc;
        logic [1:0] ck;
        logic [1:0] ddr;
    } dspac_tx_s;

    dspac_tx_s  st_ff;
    dspac_tx_s  nxt_st;
    logic [3:0] fac;
    logic [4:0] per;

    // High half of the clock pattern at half-bit index h
    function automatic logic half_hi(input logic [4:0] h,
                                     input logic [4:0] p,
                                     input logic       ctr);
        logic [5:0] t;
        t = {1'b0, h} + {5'h00, ctr};
        if (t >= {p, 1'b0}) begin
            t = t - {p, 1'b0};
        end
        half_hi = t < {1'b0, p};
    endfunction

    // Next state of serializer, clock pattern and bypass
    always_comb begin
        nxt_st = st_ff;
        fac = fact_of(cfg.txf);
        case (cfg.ck_div)
            3'h0:    per = 5'h01;
            3'h1:    per = 5'h02;
            3'h2:    per = 5'h04;
            3'h3:    per = 5'h08;
            default: per = 5'h0a;
        endcase
        if (per > {1'b0, fac}) begin
            per = {1'b0, fac}; // Divider never longer than a word
        end
        tx_load_strobe = !cfg.tx_byp && st_ff.cnt >= fac - 4'h1;
        if (cfg.tx_byp) begin
            nxt_st.cnt = '0;
            nxt_st.sh  = '0;
            nxt_st.cc  = '0;
            nxt_st.ddr = cfg.tx_ddr ? tx_word[1:0] : {2{tx_word[0]}};
        end else begin
            nxt_st.ddr = '0;
            if (tx_load_strobe) begin
                nxt_st.cnt = '0;
                nxt_st.sh  = tx_word << (WORD_MAX - fac); // MSB at top
                nxt_st.cc  = '0;
            end else begin
                nxt_st.cnt = st_ff.cnt + 4'h1;
                nxt_st.sh  = {st_ff.sh[8:0], 1'b0};
                nxt_st.cc  = 5'(st_ff.cc + 5'h02);
                if (nxt_st.cc >= {per[3:0], 1'b0}) begin
                    nxt_st.cc = '0;
                end
            end
        end
        nxt_st.ser = nxt_st.sh[9];
        // Two half-bit samples of the forwarded clock
        if (cfg.ck_en && !cfg.tx_byp) begin
            nxt_st.ck = {half_hi(nxt_st.cc, per, cfg.ck_ctr),
                         half_hi(5'(nxt_st.cc + 5'h01), per, cfg.ck_ctr)};
        end else begin
            nxt_st.ck = '0;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Registered outputs
    assign tx_serial_out = st_ff.ser;
    assign tx_clk_out    = st_ff.ck;
    assign tx_ddr_out    = st_ff.ddr;
endmodule
`default_nettype wire

//--- rtl/dspac_channel.sv
// Serdes channel top: APB registers, receive path and transmitter
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module dspac_channel
    import dspac_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [9:0]  tx_word,
    output logic             tx_load_strobe,
    output logic             tx_serial_out,
    output logic [1:0]       tx_clk_out,
    output logic [2:0]       tx_clk_phase_step,
    output logic [1:0]       tx_ddr_out,
    input  wire logic [7:0]  rx_phase_samples,
    input  wire logic        aligner_reset,
    input  wire logic        fifo_clear,
    input  wire logic        bit_slip_req,
    input  wire logic        phase_select_freeze,
    output logic [9:0]       rx_word,
    output logic             rx_word_strobe,
    output logic             phase_lock_indicator,
    output logic             slip_rollover_flag,
    output logic             recovered_word_clock,
    output logic [1:0]       rx_bypass_bits
);
    typedef struct packed {
        dspac_cfg_s  ctrl;
        logic [7:0]  smp1;
        logic [7:0]  smp2;
        logic [2:0]  phase;
        dspac_al_e   al_st;
        logic [7:0]  settle;
        logic        last_dir;
        logic        run;
        logic        lock;
        logic        ever_lock;
        logic [5:0]  fifo;
        logic [2:0]  wptr;
        logic [2:0]  rptr;
        logic [2:0]  fcnt;
        logic        primed;
        logic        slip_d;
        logic [3:0]  slip_cnt;
        logic        rflag;
        logic [10:0] dline;
        logic [9:0]  dsh;
        logic [3:0]  dcnt;
        logic [9:0]  word;
        logic        wstb;
        logic        rwc;
        logic [1:0]  byp;
        logic [31:0] prdata;
    } dspac_st_s;

    dspac_st_s   st_ff;
    dspac_st_s   nxt_st;
    dspac_cfg_s  cfg;
    dspac_cfg_s  wcfg;
    logic        edge_seen;
    logic [2:0]  tgt;
    logic [2:0]  diff;
    logic        moved;
    logic        first_lock;
    logic        fifo_rst;
    logic        abit;
    logic        fbit;
    logic        fvalid;
    logic        sbit;
    logic        svalid;
    logic        rbit;
    logic        slip_edge;
    logic [3:0]  rxf;
    logic [31:0] stat;
    logic        hit;

    // FIFO pointer step with wrap after the sixth entry
    function automatic logic [2:0] ptr_inc(input logic [2:0] p);
        ptr_inc = (p == FIFO_LAST) ? 3'h0 : p + 3'h1;
    endfunction

    // Transmit side
    dspac_tx u_tx (
        .clk            (clk),
        .rst            (rst),
        .cfg            (st_ff.ctrl),
        .tx_word        (tx_word),
        .tx_load_strobe (tx_load_strobe),
        .tx_serial_out  (tx_serial_out),
        .tx_clk_out     (tx_clk_out),
        .tx_ddr_out     (tx_ddr_out)
    );

    // APB handshake, zero wait in the access phase
    assign hit     = paddr == REG_CTRL || paddr == REG_STAT;
    assign pready  = psel && penable;
    assign pslverr = psel && penable && !hit;

    // Next state of registers and receive path
    always_comb begin
        nxt_st     = st_ff;
        cfg        = st_ff.ctrl;
        rxf        = fact_of(cfg.rxf);
        wcfg       = dspac_cfg_s'(pwdata[CTRL_W-1:0]);
        edge_seen  = 1'b0;
        tgt        = '0;
        moved      = 1'b0;
        nxt_st.wstb = 1'b0;

        // Two-stage capture of the sampled pins
        nxt_st.smp1 = rx_phase_samples;
        nxt_st.smp2 = st_ff.smp1;

        // Status word
        stat = '0;
        stat[STAT_LOCK] = st_ff.lock;
        stat[STAT_ROLL] = st_ff.rflag;
        stat[STAT_SLIP_LSB +: 4] = st_ff.slip_cnt;
        stat[STAT_PH_LSB +: 3] = st_ff.phase;
        stat[STAT_FCNT_LSB +: 3] = st_ff.fcnt;
        stat[STAT_AL_LSB +: 2] = st_ff.al_st;

        // Read data latched in the setup phase
        if (psel && !penable) begin
            if (paddr == REG_CTRL) begin
                nxt_st.prdata = {8'h00, st_ff.ctrl};
            end else if (paddr == REG_STAT) begin
                nxt_st.prdata = stat;
            end else begin
                nxt_st.prdata = '0;
            end
        end

        // Control write, rollover point clamped
        if (pready && pwrite && paddr == REG_CTRL) begin
            if (wcfg.roll < ROLL_MIN) begin
                wcfg.roll = ROLL_MIN;
            end else if (wcfg.roll > ROLL_MAX) begin
                wcfg.roll = ROLL_MAX;
            end
            nxt_st.ctrl = wcfg;
        end

        // Edge position picks the phase opposite it
        for (int i = 1; i < 8; i++) begin
            if (st_ff.smp2[i] != st_ff.smp2[i-1]) begin
                edge_seen = 1'b1;
                tgt = 3'(i + 4);
            end
        end
        diff = tgt - st_ff.phase;

        // Phase aligner
        if (aligner_reset || cfg.rx_byp) begin
            nxt_st.phase     = '0;
            nxt_st.al_st     = AL_IDLE;
            nxt_st.settle    = '0;
            nxt_st.run       = 1'b0;
            nxt_st.lock      = 1'b0;
            nxt_st.ever_lock = 1'b0;
        end else begin
            case (st_ff.al_st)
                AL_IDLE: begin
                    if (edge_seen) begin
                        nxt_st.al_st = AL_TRACK;
                    end
                end
                AL_TRACK, AL_LOCKED: begin
                    if (edge_seen && diff != 3'h0 &&
                        !phase_select_freeze) begin
                        moved           = 1'b1;
                        nxt_st.phase    = diff[2] ? st_ff.phase - 3'h1
                                                  : st_ff.phase + 3'h1;
                        nxt_st.settle   = '0;
                        nxt_st.last_dir = diff[2];
                        nxt_st.run      = 1'b1;
                        if (!cfg.lk_mode || !st_ff.lock ||
                            (st_ff.run && st_ff.last_dir == diff[2])) begin
                            nxt_st.lock  = 1'b0;
                            nxt_st.al_st = AL_TRACK;
                            nxt_st.run   = 1'b0;
                        end
                    end else if (edge_seen && diff == 3'h0 &&
                                 st_ff.al_st == AL_TRACK) begin
                        if (st_ff.settle == LOCK_SETTLE - 8'h01) begin
                            nxt_st.lock  = 1'b1;
                            nxt_st.al_st = AL_LOCKED;
                            nxt_st.run   = 1'b0;
                        end else begin
                            nxt_st.settle = st_ff.settle + 8'h01;
                        end
                    end
                end
                default: begin
                    nxt_st.al_st = AL_IDLE;
                end
            endcase
        end
        abit = st_ff.smp2[st_ff.phase];

        // First lock since reset, aligner reset or receive bypass clears the FIFO
        first_lock = nxt_st.lock && !st_ff.ever_lock;
        if (first_lock) begin
            nxt_st.ever_lock = 1'b1;
        end

        // Six-entry phase FIFO, bypassed in soft recovery
        fifo_rst = fifo_clear || first_lock || aligner_reset ||
                   cfg.scdr || cfg.rx_byp;
        fbit   = st_ff.fifo[st_ff.rptr];
        fvalid = st_ff.primed && !fifo_rst;
        if (fifo_rst) begin
            nxt_st.wptr   = '0;
            nxt_st.rptr   = '0;
            nxt_st.fcnt   = '0;
            nxt_st.primed = 1'b0;
        end else if (st_ff.al_st != AL_IDLE) begin
            nxt_st.fifo[st_ff.wptr] = abit;
            nxt_st.wptr = ptr_inc(st_ff.wptr);
            if (st_ff.primed) begin
                nxt_st.rptr = ptr_inc(st_ff.rptr);
            end else begin
                nxt_st.fcnt   = st_ff.fcnt + 3'h1;
                nxt_st.primed = st_ff.fcnt == FIFO_PRIME - 3'h1;
            end
        end

        // Bit source for realigner, none in bypass
        sbit   = cfg.scdr ? abit : fbit;
        svalid = !cfg.rx_byp &&
                 (cfg.scdr ? st_ff.al_st != AL_IDLE : fvalid);

        // Bit slip counter with rollover
        slip_edge     = bit_slip_req && !st_ff.slip_d && !cfg.rx_byp;
        nxt_st.slip_d = bit_slip_req;
        if (slip_edge) begin
            if (st_ff.slip_cnt >= cfg.roll) begin
                nxt_st.slip_cnt = '0;
            end else begin
                nxt_st.slip_cnt = st_ff.slip_cnt + 4'h1;
            end
        end
        nxt_st.rflag = nxt_st.slip_cnt == nxt_st.ctrl.roll;
        rbit = (st_ff.slip_cnt == 4'h0) ? sbit
                                        : st_ff.dline[st_ff.slip_cnt - 4'h1];

        // Delay line and deserializer
        if (svalid) begin
            nxt_st.dline = {st_ff.dline[9:0], sbit};
            nxt_st.dsh   = {st_ff.dsh[8:0], rbit};
            if (st_ff.dcnt >= rxf - 4'h1) begin
                nxt_st.dcnt = '0;
                nxt_st.word = {st_ff.dsh[8:0], rbit} &
                              (10'h3ff >> (WORD_MAX - rxf));
                nxt_st.wstb = 1'b1;
            end else begin
                nxt_st.dcnt = st_ff.dcnt + 4'h1;
            end
        end
        nxt_st.rwc = cfg.scdr && svalid &&
                     nxt_st.dcnt < (rxf >> 1);

        // Input registers in deserializer bypass
        if (cfg.rx_byp) begin
            nxt_st.byp = cfg.rx_ddr ? {st_ff.smp2[4], st_ff.smp2[0]}
                                    : {2{st_ff.smp2[0]}};
        end else begin
            nxt_st.byp = '0;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff       <= '0;
            st_ff.ctrl  <= dspac_cfg_s'(CTRL_RESET);
            st_ff.al_st <= AL_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Registered outputs
    assign prdata               = st_ff.prdata;
    assign tx_clk_phase_step    = st_ff.ctrl.ck_phase;
    assign rx_word              = st_ff.word;
    assign rx_word_strobe       = st_ff.wstb;
    assign phase_lock_indicator = st_ff.lock;
    assign slip_rollover_flag   = st_ff.rflag;
    assign recovered_word_clock = st_ff.rwc;
    assign rx_bypass_bits       = st_ff.byp;

    // Helper for the first transmitted bit
    logic [3:0] tx_fac;
    logic       tx_msb;
    assign tx_fac = fact_of(st_ff.ctrl.txf);
    assign tx_msb = tx_word[tx_fac - 4'h1];

    property p_tx_msb;
        @(posedge clk) disable iff (rst)
        tx_load_strobe |=> tx_serial_out == $past(tx_msb);
    endproperty
    a_tx_msb: assert property (p_tx_msb)
        else $error("First serial bit is not the word MSB");

    property p_tx_strobe;
        @(posedge clk) disable iff (rst)
        tx_load_strobe |=> !tx_load_strobe [*3];
    endproperty
    a_tx_strobe: assert property (p_tx_strobe)
        else $error("Transmit load strobes closer than four bits");

    property p_fifo_fill;
        @(posedge clk) disable iff (rst)
        st_ff.primed |-> st_ff.fcnt == FIFO_PRIME &&
                         st_ff.wptr != st_ff.rptr;
    endproperty
    a_fifo_fill: assert property (p_fifo_fill)
        else $error("Phase FIFO fill level wrong");

    property p_rx_strobe;
        @(posedge clk) disable iff (rst)
        rx_word_strobe |=> !rx_word_strobe [*3];
    endproperty
    a_rx_strobe: assert property (p_rx_strobe)
        else $error("Receive word strobes closer than four bits");

    property p_rx_byp;
        @(posedge clk) disable iff (rst)
        st_ff.ctrl.rx_byp |=> !phase_lock_indicator && !rx_word_strobe;
    endproperty
    a_rx_byp: assert property (p_rx_byp)
        else $error("Aligner or deserializer active in bypass");

    property p_slip_step;
        @(posedge clk) disable iff (rst)
        slip_edge && st_ff.slip_cnt < st_ff.ctrl.roll |=>
            st_ff.slip_cnt == $past(st_ff.slip_cnt) + 4'h1;
    endproperty
    a_slip_step: assert property (p_slip_step)
        else $error("Slip did not add one bit of delay");

    property p_slip_roll;
        @(posedge clk) disable iff (rst)
        slip_edge && st_ff.slip_cnt >= st_ff.ctrl.roll |=>
            st_ff.slip_cnt == 4'h0 ##1 !slip_rollover_flag;
    endproperty
    a_slip_roll: assert property (p_slip_roll)
        else $error("Slip at rollover point did not wrap");

    property p_freeze;
        @(posedge clk) disable iff (rst)
        phase_select_freeze && !aligner_reset && !st_ff.ctrl.rx_byp
            |=> $stable(st_ff.phase);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("Phase changed while frozen");

    property p_lock_drop;
        @(posedge clk) disable iff (rst)
        st_ff.lock && moved && !st_ff.ctrl.lk_mode
            |=> !phase_lock_indicator;
    endproperty
    a_lock_drop: assert property (p_lock_drop)
        else $error("Lock held across a phase move");

    property p_al_rst;
        @(posedge clk) disable iff (rst)
        aligner_reset |=> !phase_lock_indicator && st_ff.al_st == AL_IDLE;
    endproperty
    a_al_rst: assert property (p_al_rst)
        else $error("Aligner reset did not clear lock");

    property p_cdr_clk;
        @(posedge clk) disable iff (rst)
        !st_ff.ctrl.scdr |=> !recovered_word_clock;
    endproperty
    a_cdr_clk: assert property (p_cdr_clk)
        else $error("Word clock forwarded outside soft recovery");

    property p_first_lock;
        @(posedge clk) disable iff (rst)
        first_lock |=> st_ff.fcnt == 3'h0 && !st_ff.primed;
    endproperty
    a_first_lock: assert property (p_first_lock)
        else $error("FIFO not cleared on first lock");

    // Main scenarios
    c_lock: cover property (@(posedge clk) disable iff (rst)
        $rose(phase_lock_indicator));
    c_roll: cover property (@(posedge clk) disable iff (rst)
        $rose(slip_rollover_flag));
    c_word: cover property (@(posedge clk) disable iff (rst)
        rx_word_strobe && st_ff.slip_cnt != 4'h0);
    c_rwc: cover property (@(posedge clk) disable iff (rst)
        $rose(recovered_word_clock));
endmodule
`default_nettype wire

//--- dv/dspac_link_partner.sv
// Remote transmitter model driving eight-phase samples of training data
`timescale 1ns/100ps
`default_nettype none
module dspac_link_partner (
    input  wire logic       clk,
    input  wire logic [2:0] edge_ph,
    output logic [7:0]      samples
);
    logic [3:0] pat_ff  = 4'hc;
    logic       prev_ff = 1'b0;
    // Endless 1100 training, free-running on every clock
    always_ff @(posedge clk) begin
        pat_ff  <= {pat_ff[2:0], pat_ff[3]};
        prev_ff <= pat_ff[3];
    end
    // Phases ahead of the data edge still see the old bit
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            samples[i] = (i < edge_ph) ? prev_ff : pat_ff[3];
        end
    end
endmodule
`default_nettype wire

//--- dv/dspac_channel_tb.sv
// Self-checking bench for the serdes channel
`timescale 1ns/100ps
`default_nettype none
module dspac_channel_tb;
    import dspac_pkg::*;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, er;
    logic        slip_req, frz, al_rst, lock, flag;
    logic [7:0]  paddr, smp;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  tx_word;
    logic [2:0]  edge_ph;
    logic        tx_strobe, tx_ser;
    logic        fclr;
    logic [9:0]  rxw, w0;
    logic [1:0]  ckout, ddr;
    logic [2:0]  cph;
    int          fails = 0;
    int          tests_run = 0;
    int          n;
    logic [3:0]  fct [5] = '{4'h4, 4'h6, 4'h7, 4'h8, 4'ha};

    dspac_channel dspac_channel_inst (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_word(tx_word), .tx_load_strobe(tx_strobe), .tx_serial_out(tx_ser),
        .tx_clk_out(ckout), .tx_clk_phase_step(cph), .tx_ddr_out(ddr),
        .rx_phase_samples(smp), .aligner_reset(al_rst), .fifo_clear(fclr),
        .bit_slip_req(slip_req), .phase_select_freeze(frz), .rx_word(rxw),
        .rx_word_strobe(), .phase_lock_indicator(lock),
        .slip_rollover_flag(flag), .recovered_word_clock(),
        .rx_bypass_bits());
    dspac_link_partner dspac_link_partner_inst (.clk(clk), .edge_ph(edge_ph),
        .samples(smp));

    // Clock generation
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", s, e, g);
        end
    endtask
    // Slip pulse held three words high, then three low
    task automatic slip();
        @(posedge clk);
        slip_req <= 1'b1;
        repeat (12) @(posedge clk);
        slip_req <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    task automatic wait_lock();
        n = 0;
        while (lock !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        if (lock !== 1'b1) begin
            fails++;
            wrap_up();
        end
    endtask
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        wrap_up();
    end
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {fclr, slip_req, frz, al_rst, rst} = 5'h01;
        tx_word = 10'h00a;
        edge_ph = 3'h2;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl_rst", {8'h00, CTRL_RESET}, rd);
        apb(1'b0, 8'h08, 32'h0);
        chk("bad_err", 32'h1, {31'h0, er});
        chk("bad_data", 32'h0, rd);
        apb(1'b1, REG_CTRL, 32'h0);
        apb(1'b0, REG_CTRL, 32'h0);
        chk("roll_clamp", 32'h100000, rd);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, REG_CTRL, 32'h100000 | i);
            repeat (2) @(negedge clk iff tx_strobe === 1'b1);
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (tx_strobe !== 1'b1 && n < 20);
            chk("tx_period", {28'h0, fct[i]}, n);
        end
        apb(1'b1, REG_CTRL, 32'h100000);
        @(negedge clk iff tx_strobe === 1'b1);
        for (int b = 3; b >= 0; b--) begin
            @(negedge clk);
            chk("tx_bit", {31'h0, tx_word[b]}, {31'h0, tx_ser});
        end
        wait_lock();
        apb(1'b0, REG_STAT, 32'h0);
        chk("lock_phase", 32'h6, {29'h0, rd[8:6]});
        chk("lock", 32'h1, {31'h0, rd[0]});
        frz <= 1'b1;
        edge_ph <= 3'h5;
        repeat (100) @(posedge clk);
        apb(1'b0, REG_STAT, 32'h0);
        chk("frz_phase", 32'h6, {29'h0, rd[8:6]});
        @(posedge clk);
        al_rst <= 1'b1;
        @(posedge clk);
        al_rst <= 1'b0;
        @(negedge clk);
        chk("al_rst", 32'h0, {31'h0, lock});
        @(posedge clk);
        frz <= 1'b0;
        wait_lock();
        apb(1'b0, REG_STAT, 32'h0);
        chk("relock", 32'h41, {23'h0, rd[8:6], 5'h0, rd[0]});
        // Bench clears the FIFO; it restarts filling at once
        @(posedge clk);
        fclr <= 1'b1;
        @(posedge clk);
        fclr <= 1'b0;
        apb(1'b0, REG_STAT, 32'h0);
        chk("fifo_clr", 32'h1, {29'h0, rd[11:9]});
        // Settled word before any slip
        repeat (20) @(negedge clk);
        w0 = rxw;
        slip();
        apb(1'b0, REG_STAT, 32'h0);
        chk("slip_cnt", 32'h1, {28'h0, rd[5:2]});
        chk("roll_flag", 32'h1, {31'h0, flag});
        chk("slip_word", {28'h0, w0[0], w0[3:1]}, {22'h0, rxw});
        slip();
        chk("roll_wrap", 32'h0, {31'h0, flag});
        chk("roll_word", {22'h0, w0}, {22'h0, rxw});
        // Data edge moves while unfrozen, lock drops
        edge_ph <= 3'h2;
        repeat (8) @(negedge clk);
        chk("move_drop", 32'h0, {31'h0, lock});
        // Forwarded clock at bit rate, edge then center aligned
        apb(1'b1, REG_CTRL, 32'h100800);
        @(posedge clk);
        @(negedge clk);
        chk("ck_edge", 32'h2, {30'h0, ckout});
        apb(1'b1, REG_CTRL, 32'h108800);
        @(posedge clk);
        @(negedge clk);
        chk("ck_ctr", 32'h1, {30'h0, ckout});
        // Serializer bypass in double rate, phase step 3
        apb(1'b1, REG_CTRL, 32'h1300c0);
        @(posedge clk);
        @(negedge clk);
        chk("tx_ddr", 32'h2, {30'h0, ddr});
        chk("byp_strobe", 32'h0, {31'h0, tx_strobe});
        chk("ck_phase", 32'h3, {29'h0, cph});
        wrap_up();
    end
endmodule
`default_nettype wire
